// ### shared/fpep_pkg.sv
// Constants and types shared by the flash sequencer and protect decoder
package fpep_pkg;

    // Register and array map
    localparam logic [15:0] CTRL_ADDR  = 16'hFE08;
    localparam logic [15:0] PROT_ADDR  = 16'hFE09;
    localparam logic [15:0] USER_LO    = 16'hC000;
    localparam logic [15:0] USER_HI    = 16'hEFFF;
    localparam logic [15:0] VECT_LO    = 16'hFFD0;

    // Reset values
    localparam logic [3:0]  CTRL_RST   = 4'h0;
    localparam logic [7:0]  PROT_RST   = 8'h00;
    localparam logic [7:0]  PROT_OPEN  = 8'hFF;
    localparam logic [7:0]  RD_IDLE    = 8'h00;
    localparam logic [7:0]  RD_ERASED  = 8'hFF;

    // Field positions and widths
    localparam int          CTRL_W     = 4;
    localparam logic [1:0]  PROT_TOP   = 2'h3;
    localparam int          PAGE_BITS  = 7;
    localparam int          ROW_BITS   = 6;

    // Timing: clock period and least times, in ns
    localparam int          CLK_NS     = 50;
    localparam int          NVS_NS     = 10000;
    localparam int          RCV_NS     = 1000;
    localparam int          NVS_CYC    = (NVS_NS + CLK_NS - 1) / CLK_NS;
    localparam int          RCV_CYC    = (RCV_NS + CLK_NS - 1) / CLK_NS;
    localparam int          TMR_W      = 8;

    // Control register, bits 3 down to 0
    typedef struct packed {
        logic high_voltage_enable;
        logic mass;
        logic erase;
        logic program_select;
    } fpep_ctrl_t;

    // Bus request from the core
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } fpep_bus_t;

    // Program byte towards the array
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        strobe;
    } fpep_prog_t;

    // Sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_ARMED,
        SEQ_READY,
        SEQ_HIGHV,
        SEQ_RECOVER
    } fpep_seq_t;

endpackage

// ### design/fpep_protect_dec.sv
// Block protect decoder: start address and protected-target check
`timescale 1ns/10ps
module fpep_protect_dec (
    input  wire logic [7:0]  protectStartBits,
    input  wire logic [15:0] targetAddr,
    input  wire logic        massSel,
    output logic      [15:0] protectStart,
    output logic             protectedHit
);
    logic protectOff;

    // Upper seven bits land on address bits 13..7, page aligned
    assign protectStart = {fpep_pkg::PROT_TOP, protectStartBits[7:1],
                           {fpep_pkg::PAGE_BITS{1'b0}}}; // R15 R17

    // Lowest bit only counts in the all-ones open code
    assign protectOff = (protectStartBits == fpep_pkg::PROT_OPEN); // R14 R16

    // Range runs to the top of the map; mass erase hits any range
    always_comb begin
        if (protectOff) begin
            protectedHit = 1'b0;
        end else if (massSel) begin
            protectedHit = 1'b1; // R22
        end else begin
            protectedHit = (targetAddr >= protectStart); // R13
        end
    end
endmodule // fpep_protect_dec

// ### design/fpep_flash_seq.sv
// Flash program and erase sequencer with block protection
// Summary of operation
// R01 - Mass erase: software sets erase and mass, then writes into flash.
// R02 - Mass erase: software holds high voltage 4ms, drops erase, waits.
// R03 - Array reads stay blocked 1us after high voltage is cleared.
// R04 - A program row is 64 aligned bytes; low six bits pick the byte.
// R05 - With program select set, each array write address and data are kept.
// R06 - Program: set select, write into row, wait 10us, set high voltage.
// R07 - Software waits 5us after high voltage before the first byte.
// R08 - Software waits 30us per byte, then drops select, then voltage.
// R09 - Software never lets a byte's program time pass its maximum.
// R10 - Steps go in order; unrelated bus traffic may sit between them.
// R11 - Sequencing code runs from RAM, never from the flash array.
// R12 - High voltage cannot be set when the target is protected.
// R13 - Protected range runs from start address up to the map top.
// R14 - Protect value zero protects all; all ones protects nothing.
// R15 - Start address: bits 15..14 high, 13..7 from value, 6..0 low.
// R16 - Lowest protect bit only matters in the all-ones code.
// R17 - Start addresses fall only on 128-byte page boundaries.
// R18 - Program select and erase select are never both one.
// R19 - High voltage needs a select bit and the sequence so far.
// R20 - Control register bits 3..0, upper bits read zero, reset zero.
// R21 - Erased bits read one, programmed bits read zero.
// R22 - Mass erase counts as protected whenever any range is protected.
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
module fpep_flash_seq (
    input  wire logic                 clk_sys,
    input  wire logic                 sys_rst,
    input  wire logic                 clkEn,
    input  wire fpep_pkg::fpep_bus_t  busReq,
    output logic               [7:0]  busRdData,
    input  wire logic          [7:0]  arrayRdData,
    output logic                      arrayRdEn,
    output fpep_pkg::fpep_ctrl_t      flashControl,
    output fpep_pkg::fpep_prog_t      progOut,
    output logic               [15:0] rowBase,
    output logic                      readBlocked
);
    fpep_pkg::fpep_ctrl_t ctrl_r;
    fpep_pkg::fpep_ctrl_t ctrl_nxt;
    fpep_pkg::fpep_ctrl_t wrCtrl;
    fpep_pkg::fpep_seq_t  seq_r;
    fpep_pkg::fpep_seq_t  seq_nxt;
    fpep_pkg::fpep_prog_t prog_r;
    fpep_pkg::fpep_prog_t prog_nxt;
    logic [7:0]           bpr_r;
    logic [7:0]           bpr_nxt;
    logic [15:0]          latch_r;
    logic [15:0]          latch_nxt;
    logic [fpep_pkg::TMR_W-1:0] tmr_r;
    logic [fpep_pkg::TMR_W-1:0] tmr_nxt;
    logic [7:0]           rd_r;
    logic [7:0]           rd_nxt;
    logic                 inFlash;
    logic                 arrayWr;
    logic                 ctrlWr;
    logic                 hvSetReq;
    logic                 hvSetOk;
    logic                 protHit;
    logic                 sameRow;
    logic                 selNow;
    logic [15:0]          protectStart;

    // Address decode of the flash ranges
    always_comb begin
        if (busReq.addr >= fpep_pkg::USER_LO &&
            busReq.addr <= fpep_pkg::USER_HI) begin
            inFlash = 1'b1;
        end else if (busReq.addr >= fpep_pkg::VECT_LO) begin
            inFlash = 1'b1;
        end else begin
            inFlash = 1'b0;
        end
    end

    // Strobe qualifiers
    assign arrayWr  = busReq.wr && inFlash;
    assign ctrlWr   = busReq.wr && (busReq.addr == fpep_pkg::CTRL_ADDR);
    assign wrCtrl   = busReq.wdata[fpep_pkg::CTRL_W-1:0];
    assign hvSetReq = ctrlWr && wrCtrl.high_voltage_enable;
    assign sameRow  = (busReq.addr[15:fpep_pkg::ROW_BITS] ==
                       latch_r[15:fpep_pkg::ROW_BITS]); // R04

    // Protection checked against the latched target address
    fpep_protect_dec u_prot (
        .protectStartBits (bpr_r),
        .targetAddr       (latch_r),
        .massSel          (ctrl_r.erase && ctrl_r.mass),
        .protectStart     (protectStart),
        .protectedHit     (protHit)
    );

    // Voltage only after latch, setup wait and a clean protect check
    assign hvSetOk = (seq_r == fpep_pkg::SEQ_READY) &&
                     (ctrl_r.program_select || ctrl_r.erase) &&
                     !protHit; // R12 R19

    // Control and protect register writes
    always_comb begin
        ctrl_nxt = ctrl_r;
        bpr_nxt  = bpr_r;
        if (ctrlWr) begin
            ctrl_nxt.mass = wrCtrl.mass;
            // A write asking for both selects leaves them as they were
            if (!(wrCtrl.program_select && wrCtrl.erase)) begin
                ctrl_nxt.program_select = wrCtrl.program_select; // R18
                ctrl_nxt.erase          = wrCtrl.erase; // R18
            end
            if (!wrCtrl.high_voltage_enable) begin
                ctrl_nxt.high_voltage_enable = 1'b0;
            end else if (hvSetOk) begin
                ctrl_nxt.high_voltage_enable = 1'b1; // R19
            end
        end
        if (busReq.wr && busReq.addr == fpep_pkg::PROT_ADDR) begin
            bpr_nxt = busReq.wdata;
        end
    end

    assign selNow = ctrl_nxt.program_select || ctrl_nxt.erase;

    // Sequencer, latch and program capture
    always_comb begin
        seq_nxt   = seq_r;
        tmr_nxt   = tmr_r;
        latch_nxt = latch_r;
        prog_nxt  = prog_r;
        prog_nxt.strobe = 1'b0;
        if (arrayWr && ctrl_r.program_select) begin
            prog_nxt.addr = busReq.addr; // R05
            prog_nxt.data = busReq.wdata; // R05
        end
        case (seq_r)
            fpep_pkg::SEQ_IDLE: begin
                // First array write with a select bit latches the target
                if (arrayWr && (ctrl_r.program_select || ctrl_r.erase)) begin
                    seq_nxt   = fpep_pkg::SEQ_ARMED;
                    latch_nxt = busReq.addr;
                    tmr_nxt   = fpep_pkg::TMR_W'(fpep_pkg::NVS_CYC);
                end
            end
            fpep_pkg::SEQ_ARMED: begin
                tmr_nxt = tmr_r - 1'b1;
                if (!selNow) begin
                    seq_nxt = fpep_pkg::SEQ_IDLE;
                end else if (tmr_r == 8'h01) begin
                    seq_nxt = fpep_pkg::SEQ_READY; // R19
                end
            end
            fpep_pkg::SEQ_READY: begin
                if (ctrl_nxt.high_voltage_enable) begin
                    seq_nxt = fpep_pkg::SEQ_HIGHV;
                end else if (!selNow) begin
                    seq_nxt = fpep_pkg::SEQ_IDLE;
                end
            end
            fpep_pkg::SEQ_HIGHV: begin
                if (!ctrl_nxt.high_voltage_enable) begin
                    seq_nxt = fpep_pkg::SEQ_RECOVER;
                    tmr_nxt = fpep_pkg::TMR_W'(fpep_pkg::RCV_CYC); // R03
                end else if (arrayWr && ctrl_r.program_select && sameRow) begin
                    prog_nxt.strobe = 1'b1; // R04 R05
                end
            end
            fpep_pkg::SEQ_RECOVER: begin
                tmr_nxt = tmr_r - 1'b1;
                if (tmr_r == 8'h01) begin
                    seq_nxt = fpep_pkg::SEQ_IDLE; // R03
                end
            end
            default: begin
                seq_nxt = fpep_pkg::SEQ_IDLE;
            end
        endcase
    end

    // Reads blocked while voltage is up and through recovery
    assign readBlocked = (seq_r == fpep_pkg::SEQ_HIGHV) ||
                         (seq_r == fpep_pkg::SEQ_RECOVER); // R03
    assign arrayRdEn   = busReq.rd && inFlash && !readBlocked;

    // Read data path, valid for one cycle only
    always_comb begin
        rd_nxt = fpep_pkg::RD_IDLE;
        if (busReq.rd) begin
            if (busReq.addr == fpep_pkg::CTRL_ADDR) begin
                rd_nxt = {4'h0, ctrl_r}; // R20
            end else if (busReq.addr == fpep_pkg::PROT_ADDR) begin
                rd_nxt = bpr_r;
            end else if (inFlash && readBlocked) begin
                // Blocked reads show the erased pattern, not stale data
                rd_nxt = fpep_pkg::RD_ERASED; // R03 R21
            end else if (inFlash) begin
                rd_nxt = arrayRdData; // R21
            end
        end
    end

    // State registers; clock enable low freezes everything
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r  <= fpep_pkg::CTRL_RST; // R20
            bpr_r   <= fpep_pkg::PROT_RST;
            seq_r   <= fpep_pkg::SEQ_IDLE;
            tmr_r   <= '0;
            latch_r <= '0;
            prog_r  <= '0;
            rd_r    <= fpep_pkg::RD_IDLE;
        end else if (clkEn) begin
            ctrl_r  <= ctrl_nxt;
            bpr_r   <= bpr_nxt;
            seq_r   <= seq_nxt;
            tmr_r   <= tmr_nxt;
            latch_r <= latch_nxt;
            prog_r  <= prog_nxt;
            rd_r    <= rd_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign busRdData    = rd_r;
    assign flashControl = ctrl_r;
    assign progOut      = prog_r;
    assign rowBase      = {latch_r[15:fpep_pkg::ROW_BITS],
                           {fpep_pkg::ROW_BITS{1'b0}}};

    // Checks on the sequencer and protection
    sequence hvFell;
        $fell(ctrl_r.high_voltage_enable);
    endsequence

    sequence blockedHold;
        readBlocked [*8];
    endsequence

    AST_SEL_EXCLUSIVE: assert property ( // R18
        @(posedge clk_sys) disable iff (sys_rst)
        !(ctrl_r.program_select && ctrl_r.erase))
        else $error("program and erase select both set");

    AST_HV_NEEDS_SEL: assert property ( // R19
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(ctrl_r.high_voltage_enable) |->
        $past(seq_r) == fpep_pkg::SEQ_READY &&
        ($past(ctrl_r.program_select) || $past(ctrl_r.erase)))
        else $error("high voltage set without armed select");

    AST_ARMED_WAIT: assert property ( // R19
        @(posedge clk_sys) disable iff (sys_rst)
        $rose(seq_r == fpep_pkg::SEQ_ARMED) |->
        !ctrl_r.high_voltage_enable [*8])
        else $error("high voltage set during setup wait");

    AST_PROT_BLOCK: assert property ( // R12
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && hvSetReq && protHit && !ctrl_r.high_voltage_enable |=>
        !ctrl_r.high_voltage_enable)
        else $error("high voltage set on protected target");

    AST_MASS_PROT: assert property ( // R22
        @(posedge clk_sys) disable iff (sys_rst)
        ctrl_r.erase && ctrl_r.mass && bpr_r != fpep_pkg::PROT_OPEN |->
        protHit)
        else $error("mass erase not seen as protected");

    AST_START_ADDR: assert property ( // R15
        @(posedge clk_sys) disable iff (sys_rst)
        protectStart[15:14] == 2'h3 && protectStart[6:0] == 7'h00 &&
        protectStart[13:7] == bpr_r[7:1])
        else $error("protect start address malformed");

    AST_OPEN_CODES: assert property ( // R14
        @(posedge clk_sys) disable iff (sys_rst)
        (bpr_r == 8'h00 && latch_r >= fpep_pkg::USER_LO |-> protHit) and
        (bpr_r == 8'hFF |-> !protHit))
        else $error("protect all-zero or all-one code wrong");

    AST_RECOVER_HOLD: assert property ( // R03
        @(posedge clk_sys) disable iff (sys_rst)
        hvFell |-> blockedHold)
        else $error("reads unblocked too early after voltage off");

    AST_RECOVER_END: assert property ( // R03
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && seq_r == fpep_pkg::SEQ_RECOVER && tmr_r == 8'h01 |=>
        !readBlocked)
        else $error("reads stay blocked after recovery");

    AST_PROG_CAPTURE: assert property ( // R05
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && arrayWr && ctrl_r.program_select && sameRow &&
        seq_r == fpep_pkg::SEQ_HIGHV && ctrl_nxt.high_voltage_enable |=>
        progOut.strobe && progOut.addr == $past(busReq.addr) &&
        progOut.data == $past(busReq.wdata))
        else $error("program byte not captured");

    AST_CTRL_READ: assert property ( // R20
        @(posedge clk_sys) disable iff (sys_rst)
        clkEn && busReq.rd && busReq.addr == fpep_pkg::CTRL_ADDR |=>
        busRdData == {4'h0, $past(ctrl_r)})
        else $error("control register read wrong");

endmodule // fpep_flash_seq

// ### tb/fpep_array_model.sv
// Behavioural flash array that answers the sequencer's array port
`timescale 1ns/10ps
module fpep_array_model (
    input  wire logic                 clk_sys,
    input  wire logic          [15:0] addr,
    input  wire logic                 rdEn,
    input  wire fpep_pkg::fpep_ctrl_t ctrl,
    input  wire fpep_pkg::fpep_prog_t prog,
    output logic               [7:0]  rdData
);
    logic [7:0] mem [16'hC000:16'hFFFF];
    logic [7:0] lastData;
    logic       massOn;
    logic       massLast;

    // Array starts erased
    initial begin
        lastData = 8'hFF;
        massLast = 1'b0;
        for (int i = 16'hC000; i <= 16'hFFFF; i++) begin
            mem[i] = 8'hFF;
        end
    end

    // Released data lines show the inverse of the last byte, not a hold
    always @* begin
        rdData = rdEn ? mem[addr] : ~lastData;
    end

    assign massOn = ctrl.high_voltage_enable & ctrl.erase & ctrl.mass;

    // Programming only clears bits; mass erase sets every bit again, once
    // as the pump comes up, so a 4 ms hold does not rewrite the array
    // on every cycle
    always @(posedge clk_sys) begin
        if (rdEn)
            lastData <= mem[addr];
        if (prog.strobe)
            mem[prog.addr] <= mem[prog.addr] & prog.data;
        massLast <= massOn;
        if (massOn && !massLast) begin
            for (int i = 16'hC000; i <= 16'hFFFF; i++) begin
                mem[i] <= 8'hFF;
            end
        end
    end
endmodule // fpep_array_model

// ### tb/flash_program_erase_protect_test.sv
// Self-checking bench for the flash sequencer and protect decoder
`timescale 1ns/10ps
module flash_program_erase_protect_test;
    localparam int NV = fpep_pkg::NVS_CYC + 2;
    localparam int RC = fpep_pkg::RCV_CYC;
    localparam logic [15:0] CA = fpep_pkg::CTRL_ADDR;
    localparam logic [15:0] PA = fpep_pkg::PROT_ADDR;
    localparam int PGS  = 5000 / fpep_pkg::CLK_NS;
    localparam int PRG  = 30000 / fpep_pkg::CLK_NS;
    localparam int MER  = 4000000 / fpep_pkg::CLK_NS;
    localparam int NVHL = 100000 / fpep_pkg::CLK_NS;
    localparam int LIMIT = 90000;

    logic                 clk_sys, sys_rst, clkEn, arrayRdEn, readBlocked;
    fpep_pkg::fpep_bus_t  busReq;
    fpep_pkg::fpep_ctrl_t flashControl;
    fpep_pkg::fpep_prog_t progOut;
    logic [7:0]           busRdData, arrayRdData, rdv;
    logic [15:0]          rowBase;
    int                   miscompares, total_checks, cycles;
    // Table rows: protect value, latched target, whether high voltage sticks
    logic [7:0]  tProt [9] = '{8'hFF, 8'h00, 8'h01, 8'h02, 8'h03,
                               8'hFE, 8'hFE, 8'hFC, 8'hFD};
    logic [15:0] tAddr [9] = '{16'hC040, 16'hFFD0, 16'hC040, 16'hC040,
                               16'hC080, 16'hEFC0, 16'hFFD0, 16'hE000,
                               16'hFFFF};
    logic        tHv   [9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0,
                               1'b1, 1'b0, 1'b1, 1'b0};

    fpep_flash_seq dut (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .clkEn       (clkEn),
        .busReq      (busReq),
        .busRdData   (busRdData),
        .arrayRdData (arrayRdData),
        .arrayRdEn   (arrayRdEn),
        .flashControl(flashControl),
        .progOut     (progOut),
        .rowBase     (rowBase),
        .readBlocked (readBlocked)
    );

    fpep_array_model array (
        .clk_sys(clk_sys),
        .addr   (busReq.addr),
        .rdEn   (arrayRdEn),
        .ctrl   (flashControl),
        .prog   (progOut),
        .rdData (arrayRdData)
    );

    // 20 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Hang guard, about 4500 cycles above the whole run
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic report_and_stop;
        if (miscompares == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chkv(input string what, input logic [15:0] e,
                        input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask

    // One-cycle write strobe, then the bus goes quiet
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        busReq <= '{a, 8'h00, 1'b0, 1'b0};
        #1;
    endtask

    // Read data are valid only in the cycle after the strobe
    task automatic rd(input logic [15:0] a);
        @(posedge clk_sys);
        busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_sys);
        busReq <= '{a, 8'h00, 1'b0, 1'b0};
        #1;
        rdv = busRdData;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    initial begin
        miscompares = 0;
        total_checks = 0;
        cycles = 0;
        clkEn = 1'b1;
        sys_rst = 1'b1;
        busReq = '{16'h0000, 8'h00, 1'b0, 1'b0};
        repeat (3) @(posedge clk_sys);
        sys_rst <= 1'b0;
        // Reset values and an unmapped address
        rd(CA); chkv("ctrl reset", 16'h0000, rdv);
        rd(PA); chkv("protect reset", 16'h0000, rdv);
        rd(16'h1234); chkv("unmapped", 16'h0000, rdv);
        // Protect codes against latched targets
        for (int i = 0; i < 9; i++) begin
            wr(PA, tProt[i]);
            rd(PA); chkv("protect rw", {8'h00, tProt[i]}, rdv);
            wr(CA, 8'h01);
            wr(tAddr[i], 8'h00);
            idle(NV);
            wr(CA, 8'h09);
            rd(CA); chkv("hv", {12'h000, tHv[i], 3'h1}, rdv);
            wr(CA, 8'h00);
            idle(RC + 2);
        end
        // Early high voltage refused, then a row program
        wr(PA, 8'hFF);
        wr(CA, 8'h01);
        wr(16'hC040, 8'h00);
        wr(CA, 8'h09);
        rd(CA); chkv("early hv", 16'h0001, rdv);
        chkv("row base", 16'hC040, rowBase);
        idle(NV);
        wr(CA, 8'h09);
        chkv("blocked", 16'h0001, readBlocked);
        idle(PGS);
        wr(16'hC041, 8'h55);
        chkv("strobe", 16'h0001, progOut.strobe);
        chkv("prog addr", 16'hC041, progOut.addr);
        chkv("prog data", 16'h0055, progOut.data);
        idle(PRG);
        wr(16'hC0C0, 8'hAA);
        chkv("off row", 16'h0000, progOut.strobe);
        rd(16'hC041); chkv("blocked read", 16'h00FF, rdv);
        wr(CA, 8'h08);
        idle(PGS);
        wr(CA, 8'h00);
        idle(RC - 1);
        chkv("recover", 16'h0001, readBlocked);
        idle(1);
        chkv("recovered", 16'h0000, readBlocked);
        rd(16'hC041); chkv("programmed", 16'h0055, rdv);
        // Select interlock and read-as-zero upper bits
        wr(CA, 8'h03);
        rd(CA); chkv("both sel", 16'h0000, rdv);
        wr(CA, 8'h01);
        wr(CA, 8'h03);
        rd(CA); chkv("sel held", 16'h0001, rdv);
        wr(CA, 8'hF0);
        rd(CA); chkv("upper zero", 16'h0000, rdv);
        // Clock enable low: a write must not land
        clkEn <= 1'b0;
        wr(CA, 8'h01);
        clkEn <= 1'b1;
        rd(CA); chkv("frozen", 16'h0000, rdv);
        // Reset in mid-run clears the protect value left open above
        sys_rst <= 1'b1;
        idle(2);
        sys_rst <= 1'b0;
        rd(CA); chkv("mid reset ctrl", 16'h0000, rdv);
        rd(PA); chkv("mid reset prot", 16'h0000, rdv);
        // Mass erase: refused under partial protection, then done
        wr(PA, 8'hFE);
        wr(CA, 8'h06);
        wr(16'hC000, 8'h00);
        idle(NV);
        wr(CA, 8'h0E);
        rd(CA); chkv("mass prot", 16'h0006, rdv);
        wr(PA, 8'hFF);
        wr(CA, 8'h0E);
        rd(CA); chkv("mass hv", 16'h000E, rdv);
        idle(MER);
        wr(CA, 8'h0C);
        idle(NVHL);
        wr(CA, 8'h00);
        idle(RC + 2);
        rd(16'hC041); chkv("erased", 16'h00FF, rdv);
        report_and_stop();
    end
endmodule // flash_program_erase_protect_test
